// file: asu_top.sv
// Purpose: Control, data and rate logic of the asynchronous serial unit
// Assumes: One clock MCLK, synchronous active-low reset RSTN
// Notes:   Status flags other than S_TXE clear by status read followed by data access; S_TXE clears on any data write
`timescale 1ns/100ps
`default_nettype none
module asu_top
   import asu_pkg::*;
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic [2:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic SERIAL_IN,
   output logic SERIAL_OUT,
   output logic SERIAL_OUT_EN,
   output logic IRQ
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Power-of-two divider from a field
   function automatic logic [CNT_W-1:0] pow2(input logic [2:0] e);
      pow2 = CNT_W'(1) << e;
   endfunction

   // Reload value: prescale*divisor*ext, minus one; ext of zero counts as one
   function automatic logic [CNT_W-1:0] reload(input logic [1:0] p,
      input logic [2:0] d, input logic [7:0] ext);
      logic [CNT_W-1:0] base;
      base = pow2({1'b0, p}) << d;
      if (ext != 8'h00)
         reload = CNT_W'(base * CNT_W'(ext)) - CNT_W'(1);
      else
         reload = base - CNT_W'(1);
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [7:0] rdata;
      logic [7:0] ctrl1;
      logic [7:0] ctrl2;
      logic [7:0] rate;
      logic [7:0] rxext;
      logic [7:0] txext;
      logic [7:0] status;
      logic [7:0] tx_hold;
      logic [7:0] rx_hold;
      logic stat_seen;
      logic pend_pre;
      logic pend_brk;
      logic [CNT_W-1:0] tcnt;
      logic [CNT_W-1:0] rcnt;
      asu_tx_state_t tst;
      logic [3:0] tsub;
      logic [3:0] tbit;
      logic [10:0] tsh;
      logic tx_pin;
      logic tx_pin_en;
      asu_rx_state_t rst;
      logic [3:0] rsub;
      logic [3:0] rbit;
      logic [8:0] rsh;
      logic rx_par_on;
      logic rx_par_odd;
      logic noise;
      logic [3:0] idle_cnt;
      logic idle_armed;
      logic [2:0] sync;
      logic line;
      logic irq;
   } asu_state_t;

   asu_state_t q;
   asu_state_t next_q;
   always_comb
   begin
      logic tick_t;
      logic tick_r;
      logic nine;
      logic [8:0] word;
      logic par;
      logic rx_done;
      logic [7:0] ret;
      tick_t = 1'b0;
      tick_r = 1'b0;
      nine = 1'b0;
      word = 9'h000;
      par = 1'b0;
      rx_done = 1'b0;
      ret = RST_ZERO;
      next_q = q;
      // Pin synchroniser, change counts when stages two and three agree
      next_q.sync = {q.sync[1:0], SERIAL_IN};
      if (q.sync[2] == q.sync[1])
         next_q.line = q.sync[2];
      // Rate counters with 16x oversampling enables
      if (q.tcnt == CNT_W'(0))
      begin
         tick_t = 1'b1;
         next_q.tcnt = reload(q.rate[7:6], q.rate[5:3], q.txext);
      end
      else
         next_q.tcnt = q.tcnt - CNT_W'(1);
      if (q.rcnt == CNT_W'(0))
      begin
         tick_r = 1'b1;
         next_q.rcnt = reload(q.rate[7:6], q.rate[2:0], q.rxext);
      end
      else
         next_q.rcnt = q.rcnt - CNT_W'(1);

      // Register reads, one cycle later on RDATA
      if (RD)
      begin
         if (ADDR == OFS_STATUS)
         begin
            ret = q.status;
            next_q.stat_seen = 1'b1;
         end
         else if (ADDR == OFS_DATA)
            ret = q.rx_hold;
         else if (ADDR == OFS_RATE)
            ret = q.rate;
         else if (ADDR == OFS_CTRL1)
            ret = q.ctrl1;
         else if (ADDR == OFS_CTRL2)
            ret = q.ctrl2;
         else if (ADDR == OFS_RXEXT)
            ret = q.rxext;
         else if (ADDR == OFS_TXEXT)
            ret = q.txext;
         else
            ret = RST_ZERO;
      end
      next_q.rdata = ret;
      // Status then data read clears receive flags
      if (RD && ADDR == OFS_DATA && q.stat_seen)
      begin
         next_q.status[S_RXF:S_FRM] = 5'h00;
         next_q.status[S_PAR] = 1'b0;
         next_q.stat_seen = 1'b0;
      end
      // Register writes
      if (WR)
      begin
         if (ADDR == OFS_DATA)
         begin
            next_q.tx_hold = WDATA;
            next_q.status[S_TXE] = 1'b0;
            if (q.stat_seen)
               next_q.status[S_TXC] = 1'b0;
            next_q.stat_seen = 1'b0;
         end
         else if (ADDR == OFS_RATE)
            next_q.rate = WDATA;
         else if (ADDR == OFS_CTRL1)
            next_q.ctrl1 = {q.ctrl1[C1_RX9], WDATA[6:0]};
         else if (ADDR == OFS_CTRL2)
         begin
            next_q.ctrl2 = WDATA;
            // Enable pulse during a frame queues a preamble
            if (q.ctrl2[C2_TX_ON] && !WDATA[C2_TX_ON] && q.tst == TX_SHIFT)
               next_q.pend_pre = 1'b1;
            // Break released queues one break word
            if (q.ctrl2[C2_BRK] && !WDATA[C2_BRK])
               next_q.pend_brk = 1'b1;
         end
         else if (ADDR == OFS_RXEXT)
            next_q.rxext = WDATA;
         else if (ADDR == OFS_TXEXT)
            next_q.txext = WDATA;
      end
      // Transmitter: pin owned only while enabled
      nine = q.ctrl1[C1_WLEN];
      next_q.tx_pin_en = next_q.ctrl2[C2_TX_ON];
      if (q.tst == TX_IDLE)
      begin
         next_q.tx_pin = 1'b1;
         if (q.ctrl2[C2_TX_ON] && tick_t)
         begin
            word = {q.ctrl1[C1_TX9], q.tx_hold};
            // Parity replaces MSB; settings taken per byte
            par = q.ctrl1[C1_PAR_ODD] ^
               (nine ? ^word[7:0] : ^word[6:0]);
            if (q.ctrl1[C1_PAR_ON] && nine)
               word[8] = par;
            else if (q.ctrl1[C1_PAR_ON])
               word[7] = par;
            if (q.ctrl2[C2_BRK] || q.pend_brk)
            begin
               next_q.tsh = 11'h000;
               next_q.pend_brk = 1'b0;
               next_q.tst = TX_SHIFT;
            end
            else if (q.pend_pre)
            begin
               next_q.tsh = 11'h7ff;
               next_q.pend_pre = 1'b0;
               next_q.tst = TX_SHIFT;
            end
            else if (!q.status[S_TXE])
            begin
               // Start, data LSB first, stop
               next_q.tsh = nine ? {1'b1, word, 1'b0}
                                 : {2'b11, word[7:0], 1'b0};
               next_q.status[S_TXE] = 1'b1;
               next_q.tst = TX_SHIFT;
            end
            next_q.tsub = 4'h0;
            next_q.tbit = nine ? BITS_9 : BITS_8;
         end
      end
      else if (tick_t)
      begin
         next_q.tx_pin = q.tsh[0];
         next_q.tsub = q.tsub + 4'h1;
         if (q.tsub == LAST_SAMPLE)
         begin
            next_q.tsh = {1'b1, q.tsh[10:1]};
            if (q.tbit == 4'h0)
            begin
               next_q.tst = TX_IDLE;
               next_q.status[S_TXC] = 1'b1;
            end
            else
               next_q.tbit = q.tbit - 4'h1;
         end
      end
      // Receiver: hunt for start bit when enabled
      if (!q.ctrl2[C2_RX_ON])
      begin
         next_q.rst = RX_HUNT;
         next_q.status[S_RXF:S_FRM] = 5'h00;
         next_q.idle_cnt = 4'h0;
      end
      else if (tick_r)
      begin
         next_q.rsub = q.rsub + 4'h1;
         if (q.rst == RX_HUNT)
         begin
            if (!q.line)
            begin
               next_q.rst = RX_SHIFT;
               next_q.rsub = 4'h0;
               next_q.rbit = 4'h0;
               next_q.rx_par_on = q.ctrl1[C1_PAR_ON];
               next_q.rx_par_odd = q.ctrl1[C1_PAR_ODD];
               next_q.idle_cnt = 4'h0;
               next_q.idle_armed = 1'b1;
            end
            else if (q.rsub == LAST_SAMPLE && q.idle_armed)
            begin
               next_q.idle_cnt = q.idle_cnt + 4'h1;
               if (q.idle_cnt == (nine ? BITS_9 : BITS_8))
               begin
                  next_q.idle_armed = 1'b0;
                  if (q.ctrl2[C2_MUTE] && !q.ctrl1[C1_WAKE])
                     next_q.ctrl2[C2_MUTE] = 1'b0;
                  else if (!q.ctrl2[C2_MUTE])
                     next_q.status[S_IDLE] = 1'b1;
               end
            end
         end
         else if (q.rsub == MID_SAMPLE)
         begin
            if (q.rbit == 4'h0 && q.line)
               next_q.rst = RX_HUNT; // False start
            else if (q.rbit == (nine ? BITS_9 : BITS_8))
            begin
               rx_done = 1'b1;
               next_q.rst = RX_HUNT;
            end
            else if (q.rbit != 4'h0)
               next_q.rsh = nine ? {q.line, q.rsh[8:1]}
                                 : {1'b0, q.line, q.rsh[7:1]};
            next_q.rbit = q.rbit + 4'h1;
         end
      end
      // Word complete: mute gate, address wake, flags
      if (rx_done)
      begin
         word = q.rsh;
         if (q.ctrl2[C2_MUTE] && q.ctrl1[C1_WAKE] &&
            (nine ? word[8] : word[7]))
            next_q.ctrl2[C2_MUTE] = 1'b0;
         if (!q.ctrl2[C2_MUTE] || next_q.ctrl2[C2_MUTE] == 1'b0)
         begin
            if (q.status[S_RXF])
               next_q.status[S_OVR] = 1'b1;
            else
            begin
               next_q.rx_hold = word[7:0];
               next_q.ctrl1[C1_RX9] = word[8];
               next_q.status[S_RXF] = 1'b1;
               next_q.status[S_FRM] = !q.line;
               par = q.rx_par_odd ^ (nine ? ^word[8:0] : ^word[7:0]);
               if (q.rx_par_on && par)
                  next_q.status[S_PAR] = 1'b1;
            end
         end
      end
      // Interrupt merge
      next_q.irq =
         (q.ctrl1[C1_PAR_IRQ] & q.status[S_PAR]) |
         (q.ctrl2[C2_TXE_IRQ] & q.status[S_TXE]) |
         (q.ctrl2[C2_TXC_IRQ] & q.status[S_TXC]) |
         (!q.ctrl2[C2_MUTE] & q.ctrl2[C2_RXF_IRQ] &
            (q.status[S_RXF] | q.status[S_OVR])) |
         (!q.ctrl2[C2_MUTE] & q.ctrl2[C2_IDL_IRQ] & q.status[S_IDLE]);
   end

   // Register the state; reset to constants
   always_ff @(posedge MCLK)
   begin
      if (!RSTN)
      begin
         q <= '0;
         q.status <= 8'hc0;
         q.tx_pin <= 1'b1;
         q.sync <= 3'h7;
         q.line <= 1'b1;
      end
      else
         q <= next_q;
   end

   assign RDATA = q.rdata;
   assign SERIAL_OUT = q.tx_pin;
   assign SERIAL_OUT_EN = q.tx_pin_en;
   assign IRQ = q.irq;
   // Any mute release, by hardware or by register write, excused by the mute assertion
   logic rx_wake;
   assign rx_wake = q.ctrl2[C2_MUTE] && !next_q.ctrl2[C2_MUTE];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RSTN);

   a_rx_off_clear: assert property (!q.ctrl2[C2_RX_ON] |=>
      !q.status[S_RXF] && !q.status[S_OVR])
      else $error("receive flags not cleared");
   a_pin_owner: assert property (WR && ADDR == OFS_CTRL2 |=>
      SERIAL_OUT_EN == $past(WDATA[C2_TX_ON]))
      else $error("pin ownership wrong");
   a_txe_irq: assert property (q.ctrl2[C2_TXE_IRQ] && q.status[S_TXE]
      |=> IRQ) else $error("empty irq missing");
   a_txc_irq: assert property (q.ctrl2[C2_TXC_IRQ] && q.status[S_TXC]
      |=> IRQ) else $error("complete irq missing");
   a_par_irq: assert property (q.ctrl1[C1_PAR_IRQ] && q.status[S_PAR]
      |=> IRQ) else $error("parity irq missing");
   a_idle_irq: assert property (q.ctrl2[C2_IDL_IRQ] && q.status[S_IDLE] &&
      !q.ctrl2[C2_MUTE] |=> IRQ) else $error("idle irq missing");
   a_mute_quiet: assert property (q.ctrl2[C2_MUTE] && !q.status[S_RXF]
      && !rx_wake |=> !q.status[S_RXF]) else $error("flag set while muted");
   a_data_read: assert property (RD && ADDR == OFS_DATA |=>
      RDATA == $past(q.rx_hold)) else $error("data read wrong");
   a_ext_reset: assert property ($rose(RSTN) |->
      q.rxext == 8'h00 && q.txext == 8'h00) else $error("ext not zero");
endmodule // asu_top
`default_nettype wire

// file: asu_pkg.sv
// Purpose: Constants for the asynchronous serial unit (control, data, rate)
// Assumes: 8-bit register port, byte-wide registers at small offsets
// Notes:   Offsets are local choices; divisor tables use powers of two
`default_nettype none
package asu_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [2:0] OFS_STATUS = 3'h0;
   localparam logic [2:0] OFS_DATA = 3'h1;
   localparam logic [2:0] OFS_RATE = 3'h2;
   localparam logic [2:0] OFS_CTRL1 = 3'h3;
   localparam logic [2:0] OFS_CTRL2 = 3'h4;
   localparam logic [2:0] OFS_RXEXT = 3'h5;
   localparam logic [2:0] OFS_TXEXT = 3'h6;
   // ----------------------------------------------------------------
   // Control 1 fields
   // ----------------------------------------------------------------
   localparam int C1_RX9 = 7;
   localparam int C1_TX9 = 6;
   localparam int C1_WLEN = 4;
   localparam int C1_WAKE = 3;
   localparam int C1_PAR_ON = 2;
   localparam int C1_PAR_ODD = 1;
   localparam int C1_PAR_IRQ = 0;
   // ----------------------------------------------------------------
   // Control 2 fields
   // ----------------------------------------------------------------
   localparam int C2_TXE_IRQ = 7;
   localparam int C2_TXC_IRQ = 6;
   localparam int C2_RXF_IRQ = 5;
   localparam int C2_IDL_IRQ = 4;
   localparam int C2_TX_ON = 3;
   localparam int C2_RX_ON = 2;
   localparam int C2_MUTE = 1;
   localparam int C2_BRK = 0;
   // ----------------------------------------------------------------
   // Status fields and reset values
   // ----------------------------------------------------------------
   localparam int S_TXE = 7;
   localparam int S_TXC = 6;
   localparam int S_RXF = 5;
   localparam int S_IDLE = 4;
   localparam int S_OVR = 3;
   localparam int S_NOISE = 2;
   localparam int S_FRM = 1;
   localparam int S_PAR = 0;
   localparam logic [7:0] RST_ZERO = 8'h00;
   // ----------------------------------------------------------------
   // Rate generator constants
   // ----------------------------------------------------------------
   localparam int OVERSAMPLE = 16;
   localparam logic [3:0] MID_SAMPLE = 4'h7;
   localparam logic [3:0] LAST_SAMPLE = 4'hf;
   localparam logic [3:0] BITS_8 = 4'h9;
   localparam logic [3:0] BITS_9 = 4'ha;
   localparam int CNT_W = 18; // Holds 8 x 128 x 255 cycle periods
   typedef enum logic [1:0] {TX_IDLE = 2'b00, TX_SHIFT = 2'b01}
      asu_tx_state_t;
   typedef enum logic [1:0] {RX_HUNT = 2'b00, RX_SHIFT = 2'b01}
      asu_rx_state_t;
endpackage : asu_pkg
`default_nettype wire

// file: asu_remote.sv
// Purpose: Remote serial node facing the asynchronous serial unit
// Assumes: Bit time is a whole number of bench clock cycles
// Notes:   Line idles high, as pulled up, outside its own frames
`timescale 1ns/100ps
`default_nettype none
module asu_remote (
   input wire logic clk,
   input wire logic line_in,
   input wire logic line_en,
   input wire logic nine,
   input wire logic [7:0] bitc,
   output logic line_out,
   output logic got,
   output logic [8:0] word
);
   // Idle line at time zero
   initial
   begin
      line_out = 1'b1;
      got = 1'b0;
      word = 9'h000;
   end

   // Sends start, data LSB first, stop; frame bits built at the call, bit count read from nine on every bit
   task automatic send(input logic [8:0] w);
      logic [10:0] f;
      f = nine ? {1'b1, w, 1'b0} : {2'b11, w[7:0], 1'b0};
      for (int i = 0; i < (nine ? 11 : 10); i++)
      begin
         line_out <= f[i];
         repeat (bitc) @(posedge clk);
      end
   endtask

   // Samples each bit mid-cell; a low stop gives no strobe
   always
   begin : rx_side
      logic [8:0] w;
      @(negedge line_in);
      if (line_en)
      begin
         w = 9'h000;
         repeat (bitc / 2) @(posedge clk);
         for (int i = 0; i < (nine ? 9 : 8); i++)
         begin
            repeat (bitc) @(posedge clk);
            w[i] = line_in;
         end
         repeat (bitc) @(posedge clk);
         word <= w;
         got <= line_in;
         @(posedge clk);
         got <= 1'b0;
      end
   end
endmodule // asu_remote
`default_nettype wire

// file: async_serial_ctrl_baud_test.sv
// Purpose: Self-checking bench for the asynchronous serial unit
// Assumes: Rate register zero gives sixteen cycles a bit
// Notes:   Expected words and reads are queued, then compared
`timescale 1ns/100ps
`default_nettype none
module async_serial_ctrl_baud_test;
   import asu_pkg::*;
   logic MCLK, RSTN, WR, RD, SERIAL_OUT, SERIAL_OUT_EN, IRQ, SERIAL_IN;
   logic [2:0] ADDR;
   logic [7:0] WDATA, RDATA, bitc, d;
   logic nine, got, rd_pend;
   logic [8:0] word;
   logic [8:0] txq[$];
   logic [7:0] rdq[$];
   string rdn[$];
   int n_errors = 0;
   int comparisons = 0;
   logic [7:0] c1[5] = '{8'h00, 8'h04, 8'h06, 8'h50, 8'h14};

   asu_top asu_top_inst (.MCLK(MCLK), .RSTN(RSTN), .ADDR(ADDR),
      .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
      .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT),
      .SERIAL_OUT_EN(SERIAL_OUT_EN), .IRQ(IRQ));
   asu_remote asu_remote_inst (.clk(MCLK), .line_in(SERIAL_OUT),
      .line_en(SERIAL_OUT_EN), .nine(nine), .bitc(bitc),
      .line_out(SERIAL_IN), .got(got), .word(word));

   // Clock source
   initial
   begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end

   // ----------------------------------------------------------------
   // Checking and bus tasks
   // ----------------------------------------------------------------
   task automatic complete_run;
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [8:0] e,
                      input logic [8:0] g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge MCLK);
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= v;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask

   task automatic rd(input logic [2:0] a, input logic [7:0] e,
                     input string nm);
      rdq.push_back(e);
      rdn.push_back(nm);
      @(posedge MCLK);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge MCLK);
      RD <= 1'b0;
   endtask

   // Bounded wait: 0 interrupt, 1 pin owner, 2 transmit queue empty
   task automatic wait_on(input string nm, input int s, input logic v);
      int k;
      for (k = 0; k < 4000; k++)
      begin
         @(negedge MCLK);
         if ((s == 0 ? IRQ : s == 1 ? SERIAL_OUT_EN :
             (txq.size() == 0)) === v)
            break;
      end
      comparisons++;
      if (k == 4000)
      begin
         n_errors++;
         $display("[FAIL] %s expected %b seen %b", nm, v, ~v);
         complete_run();
      end
   endtask

   // Word on the line for a control 1 setting
   function automatic logic [8:0] expw(input logic [7:0] c,
                                       input logic [7:0] v);
      logic p;
      p = (c[C1_WLEN] ? ^v : ^v[6:0]) ^ c[C1_PAR_ODD];
      if (!c[C1_PAR_ON])
         return c[C1_WLEN] ? {c[C1_TX9], v} : {1'b0, v};
      return c[C1_WLEN] ? {p, v} : {1'b0, p, v[6:0]};
   endfunction

   // Frame sent, control 1 changed mid-frame to m
   task automatic txf(input logic [7:0] v, input logic [8:0] e,
                      input logic [7:0] m);
      txq.push_back(e);
      wr(OFS_DATA, v);
      repeat (40) @(posedge MCLK);
      wr(OFS_CTRL1, m);
      wait_on("tx word", 2, 1'b1);
      repeat (bitc) @(posedge MCLK);
   endtask

   // Frame received with receive and idle interrupts on
   task automatic rxf(input logic [7:0] v);
      asu_remote_inst.send({1'b0, v});
      wait_on("irq", 0, 1'b1);
      rd(OFS_STATUS, 8'he0, "status");
      rd(OFS_DATA, v, "rx data");
      wait_on("irq", 0, 1'b0);
      wait_on("idle irq", 0, 1'b1);
      rd(OFS_STATUS, 8'hd0, "status");
      rd(OFS_DATA, v, "rx data");
      wait_on("irq", 0, 1'b0);
   endtask

   // ----------------------------------------------------------------
   // Result watchers
   // ----------------------------------------------------------------
   always @(posedge MCLK) rd_pend <= RD;

   // Read data stands in the cycle after the strobe
   always @(negedge MCLK)
   begin
      if (rd_pend)
         chk(rdn.pop_front(), {1'b0, rdq.pop_front()}, {1'b0, RDATA});
      if (got)
         chk("tx word", txq.pop_front(), word);
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      RSTN = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = 3'h0;
      WDATA = 8'h00;
      nine = 1'b0;
      bitc = 8'h10;
      void'($urandom(75));
      repeat (16) @(posedge MCLK);
      RSTN <= 1'b1;
      rd(OFS_STATUS, 8'hc0, "status");
      rd(OFS_CTRL2, RST_ZERO, "ctrl2");
      rd(OFS_RATE, RST_ZERO, "rate");
      rd(OFS_RXEXT, RST_ZERO, "rx ext");
      rd(OFS_TXEXT, RST_ZERO, "tx ext");
      d = 8'($urandom);
      wr(OFS_RXEXT, d);
      rd(OFS_RXEXT, d, "rx ext");
      wr(3'h7, 8'hff);
      rd(3'h7, 8'h00, "unmapped");
      rd(OFS_RXEXT, d, "rx ext");
      wr(OFS_RXEXT, RST_ZERO);
      wr(OFS_CTRL2, 8'h80);
      wait_on("irq", 0, 1'b1);
      wr(OFS_CTRL2, 8'h00);
      wait_on("irq", 0, 1'b0);
      wr(OFS_CTRL2, 8'h0c);
      wait_on("pin owner", 1, 1'b1);
      // Formats and parity, with parity bits changed mid-frame
      for (int i = 0; i < 5; i++)
      begin
         d = 8'($urandom);
         nine = c1[i][C1_WLEN];
         wr(OFS_CTRL1, c1[i]);
         txf(d, expw(c1[i], d),
             (c1[i] & 8'hf8) | (c1[(i + 1) % 5] & 8'h07));
      end
      nine = 1'b0;
      wr(OFS_CTRL1, 8'h00);
      wr(OFS_CTRL2, 8'h3c);
      // Slower rates through extended and conventional dividers
      bitc = 8'h20;
      wr(OFS_TXEXT, 8'h02);
      wr(OFS_RXEXT, 8'h02);
      d = 8'($urandom);
      txf(d, {1'b0, d}, 8'h00);
      rxf(8'($urandom));
      wr(OFS_TXEXT, RST_ZERO);
      wr(OFS_RXEXT, RST_ZERO);
      wr(OFS_RATE, 8'h09);
      d = 8'($urandom);
      txf(d, {1'b0, d}, 8'h00);
      rxf(8'($urandom));
      wr(OFS_RATE, RST_ZERO);
      bitc = 8'h10;
      // Parity error raises the interrupt
      wr(OFS_CTRL1, 8'h05);
      wr(OFS_CTRL2, 8'h0c);
      d = 8'($urandom);
      d[7] = ~^d[6:0];
      asu_remote_inst.send({1'b0, d});
      wait_on("irq", 0, 1'b1);
      rd(OFS_STATUS, 8'he1, "status");
      rd(OFS_DATA, d, "rx data");
      wait_on("irq", 0, 1'b0);
      // Receiver disable drops receive flags
      wr(OFS_CTRL1, 8'h00);
      asu_remote_inst.send(9'h05a);
      repeat (16) @(posedge MCLK);
      wr(OFS_CTRL2, 8'h08);
      rd(OFS_STATUS, 8'hc0, "status");
      // Address mark wake from mute, after a data word was ignored
      wr(OFS_CTRL1, 8'h08);
      wr(OFS_CTRL2, 8'h2e);
      asu_remote_inst.send(9'h035);
      repeat (16) @(posedge MCLK);
      rd(OFS_STATUS, 8'hc0, "status");
      @(negedge MCLK);
      chk("irq", 9'h000, {8'h00, IRQ});
      asu_remote_inst.send(9'h0a5);
      wait_on("irq", 0, 1'b1);
      rd(OFS_CTRL2, 8'h2c, "ctrl2");
      rd(OFS_STATUS, 8'he0, "status");
      rd(OFS_DATA, 8'ha5, "rx data");
      // Idle line wake from mute leaves the idle flag clear
      wr(OFS_CTRL1, 8'h00);
      wr(OFS_CTRL2, 8'h1e);
      repeat (200) @(posedge MCLK);
      rd(OFS_CTRL2, 8'h1c, "ctrl2");
      rd(OFS_STATUS, 8'hc0, "status");
      wr(OFS_CTRL2, 8'h00);
      wait_on("pin owner", 1, 1'b0);
      complete_run();
   end
endmodule // async_serial_ctrl_baud_test
`default_nettype wire
